// ---- uecc_top.sv ----
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module uecc_top (
    input wire logic clk,
    input wire logic rst,
    // lite register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // peripheral-side endpoint query from the serial engine
    input wire logic [uecc_pkg::UECC_EP_IDX_W-1:0] tokenEndpoint,
    input wire logic tokenIsSetup,
    input wire logic tokenIsIn,
    output uecc_pkg::uecc_hs_t tokenAnswer,
    output logic tokenAccept,
    // host-side transaction result from the serial engine
    input wire logic hostNakSeen,
    output logic hostRetry,
    output logic hostNakComplete,
    // configuration outputs
    output logic [31:0] descriptorTableBaseAddress,
    output logic hostMode,
    output logic hostHandshakeEnable,
    output logic directLowSpeed,
    output logic sendPreamble,
    output logic nakRetryDisable,
    output logic transceiverSuspend,
    output logic weakPulldownEnable,
    output logic [1:0] usbClockSelect,
    output logic usbClockSelectValid
);
    import uecc_pkg::*;

    typedef struct packed {
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [7:0] baseTop;
        logic [7:0] xcvrCtrl;
        logic [7:0] genCtrl;
        logic [1:0] hsAnswer;
        logic accept;
        logic retry;
        logic nakDone;
    } uecc_state_t;

    uecc_state_t state_reg;
    uecc_state_t state_next;

    logic [7:0] epValue [UECC_NUM_EP];
    logic [UECC_NUM_EP-1:0] epWrite;
    logic wrFire;
    logic rdFire;
    logic wrIsEp;
    logic [UECC_EP_IDX_W-1:0] wrEpIdx;
    logic [UECC_EP_IDX_W-1:0] rdEpIdx;
    logic decAccept;
    logic decStall;
    logic decHshk;
    logic [7:0] selCtrl;

    // write decode; endpoint window covers sixteen aligned words
    assign wrFire = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;
    assign rdFire = s_axi_arvalid && !state_reg.rValid;
    // an unaligned word inside the window must not alias onto an endpoint
    assign wrIsEp = state_reg.awAddr >= UECC_OFS_EP_FIRST && state_reg.awAddr <= UECC_OFS_EP_LAST
        && state_reg.awAddr[1:0] == 2'h0;
    assign wrEpIdx = state_reg.awAddr[UECC_EP_IDX_W+1:2];
    assign rdEpIdx = s_axi_araddr[UECC_EP_IDX_W+1:2];

    // sixteen endpoint bytes; only endpoint zero keeps the host-only bits
    genvar gi;
    generate
        for (gi = 0; gi < UECC_NUM_EP; gi++) begin : g_ep
            assign epWrite[gi] = wrFire && wrIsEp && state_reg.wStrb[0]
                && wrEpIdx == UECC_EP_IDX_W'(gi);
            uecc_ep_slot #(
                .FIELD_MASK(gi == 0 ? EP_MASK : EP_MASK_NONZERO)
            ) u_slot (
                .clk(clk),
                .rst(rst),
                .wrEn(epWrite[gi]),
                .wrData(state_reg.wData[7:0]),
                .value(epValue[gi])
            );
        end
    endgenerate

    // host mode always uses endpoint zero, peripheral mode the token's one
    assign selCtrl = state_reg.genCtrl[GEN_HOST_EN] ? epValue[0] : epValue[tokenEndpoint];

    uecc_ep_decode u_dec (
        .ctrlByte(selCtrl),
        .isSetup(tokenIsSetup),
        .isIn(tokenIsIn),
        .accept(decAccept),
        .stall(decStall),
        .handshake(decHshk)
    );

    // next state: bus slave, config bytes and registered endpoint answers
    always_comb begin
        state_next = state_reg;
        // address and data taken independently, in either order
        if (s_axi_awvalid && !state_reg.awHeld) begin
            state_next.awHeld = 1'b1;
            state_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.wHeld) begin
            state_next.wHeld = 1'b1;
            state_next.wData = s_axi_wdata;
            state_next.wStrb = s_axi_wstrb;
        end
        if (state_reg.bValid && s_axi_bready) begin
            state_next.bValid = 1'b0;
        end
        if (wrFire) begin
            state_next.awHeld = 1'b0;
            state_next.wHeld = 1'b0;
            state_next.bValid = 1'b1;
            state_next.bResp = RESP_OKAY;
            if (state_reg.awAddr == UECC_OFS_BASE_TOP) begin
                if (state_reg.wStrb[0]) begin
                    state_next.baseTop = state_reg.wData[7:0];
                end
            end else if (state_reg.awAddr == UECC_OFS_XCVR_CTRL) begin
                if (state_reg.wStrb[0]) begin
                    state_next.xcvrCtrl = state_reg.wData[7:0] & XC_MASK;
                end
            end else if (state_reg.awAddr == UECC_OFS_GEN_CTRL) begin
                if (state_reg.wStrb[0]) begin
                    state_next.genCtrl = state_reg.wData[7:0] & GEN_MASK;
                end
            end else if (!wrIsEp) begin
                state_next.bResp = RESP_SLVERR; // unmapped word
            end
        end
        // reads answer the cycle after arvalid is taken
        if (state_reg.rValid && s_axi_rready) begin
            state_next.rValid = 1'b0;
        end
        if (rdFire) begin
            state_next.rValid = 1'b1;
            state_next.rResp = RESP_OKAY;
            state_next.rData = '0;
            if (s_axi_araddr == UECC_OFS_BASE_TOP) begin
                state_next.rData[7:0] = state_reg.baseTop;
            end else if (s_axi_araddr == UECC_OFS_XCVR_CTRL) begin
                state_next.rData[7:0] = state_reg.xcvrCtrl;
            end else if (s_axi_araddr == UECC_OFS_GEN_CTRL) begin
                state_next.rData[7:0] = state_reg.genCtrl;
            end else if (s_axi_araddr >= UECC_OFS_EP_FIRST && s_axi_araddr <= UECC_OFS_EP_LAST
                && s_axi_araddr[1:0] == 2'h0) begin
                state_next.rData[7:0] = epValue[rdEpIdx];
            end else begin
                state_next.rResp = RESP_SLVERR;
            end
        end
        // endpoint answer: stall, handshake, or silent for isochronous
        state_next.accept = decAccept;
        if (decStall) begin
            state_next.hsAnswer = UECC_HS_STALL;
        end else if (decAccept && decHshk) begin
            state_next.hsAnswer = UECC_HS_ACK;
        end else begin
            state_next.hsAnswer = UECC_HS_NONE;
        end
        // host nak: retry in hardware or finish and report
        state_next.retry = state_reg.genCtrl[GEN_HOST_EN] && hostNakSeen
            && !epValue[0][EP_NAK_NORETRY];
        state_next.nakDone = state_reg.genCtrl[GEN_HOST_EN] && hostNakSeen
            && epValue[0][EP_NAK_NORETRY];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // bus handshake outputs
    assign s_axi_awready = !state_reg.awHeld;
    assign s_axi_wready = !state_reg.wHeld;
    assign s_axi_bvalid = state_reg.bValid;
    assign s_axi_bresp = state_reg.bResp;
    assign s_axi_arready = !state_reg.rValid;
    assign s_axi_rvalid = state_reg.rValid;
    assign s_axi_rdata = state_reg.rData;
    assign s_axi_rresp = state_reg.rResp;

    // endpoint and host results, all from flip-flops
    assign tokenAnswer = uecc_hs_t'(state_reg.hsAnswer);
    assign tokenAccept = state_reg.accept;
    assign hostRetry = state_reg.retry;
    assign hostNakComplete = state_reg.nakDone;

    // base address alignment is structural: low 24 bits never stored
    assign descriptorTableBaseAddress = {state_reg.baseTop, 15'h0000, {UECC_BASE_ALIGN_BITS{1'b0}}};
    assign hostMode = state_reg.genCtrl[GEN_HOST_EN];
    assign hostHandshakeEnable = epValue[0][EP_HANDSHAKE];
    assign directLowSpeed = hostMode && epValue[0][EP_DIRECT_LS];
    assign sendPreamble = hostMode && !epValue[0][EP_DIRECT_LS];
    assign nakRetryDisable = hostMode && epValue[0][EP_NAK_NORETRY];
    assign transceiverSuspend = state_reg.xcvrCtrl[XC_SUSPEND];
    assign weakPulldownEnable = state_reg.xcvrCtrl[XC_PULLDOWN];
    assign usbClockSelect = state_reg.xcvrCtrl[1:0];
    assign usbClockSelectValid = state_reg.xcvrCtrl[1:0] != CLKSEL_RSVD;
endmodule

// ---- uecc_pkg.sv ----
package uecc_pkg;
    // register byte offsets on the lite bus
    localparam logic [7:0] UECC_OFS_BASE_TOP = 8'h00;
    localparam logic [7:0] UECC_OFS_XCVR_CTRL = 8'h04;
    localparam logic [7:0] UECC_OFS_GEN_CTRL = 8'h08;
    localparam logic [7:0] UECC_OFS_EP_FIRST = 8'h40;
    localparam logic [7:0] UECC_OFS_EP_LAST = 8'h7c;
    localparam int UECC_NUM_EP = 16;
    localparam int UECC_EP_IDX_W = 4;
    localparam int UECC_BASE_ALIGN_BITS = 9;
    // endpoint control field positions
    localparam int EP_DIRECT_LS = 7;
    localparam int EP_NAK_NORETRY = 6;
    localparam int EP_SETUP_DIS = 4;
    localparam int EP_RX_DIR = 3;
    localparam int EP_TX_DIR = 2;
    localparam int EP_HALT = 1;
    localparam int EP_HANDSHAKE = 0;
    localparam logic [7:0] EP_MASK = 8'hdf;
    localparam logic [7:0] EP_MASK_NONZERO = 8'h1f;
    // transceiver control field positions
    localparam int XC_SUSPEND = 7;
    localparam int XC_PULLDOWN = 6;
    localparam logic [7:0] XC_MASK = 8'hc3;
    localparam logic [1:0] CLKSEL_ALT_PIN = 2'h0;
    localparam logic [1:0] CLKSEL_OSC = 2'h1;
    localparam logic [1:0] CLKSEL_RSVD = 2'h2;
    localparam logic [1:0] CLKSEL_PLL = 2'h3;
    localparam int GEN_HOST_EN = 0;
    localparam logic [7:0] GEN_MASK = 8'h01;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // handshake answer codes on the endpoint query port
    typedef enum logic [1:0] {
        UECC_HS_NONE,
        UECC_HS_ACK,
        UECC_HS_STALL
    } uecc_hs_t;
endpackage

// ---- uecc_ep_slot.sv ----
`timescale 1ns/100ps
// one endpoint control byte, reserved bits forced to zero
module uecc_ep_slot #(
    parameter logic [7:0] FIELD_MASK = 8'hdf
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    output logic [7:0] value
);
    import uecc_pkg::*;
    typedef struct packed {
        logic [7:0] ctrlByte;
    } uecc_slot_t;
    uecc_slot_t state_reg;
    uecc_slot_t state_next;

    // a write replaces the byte; halt stays until software rewrites it
    always_comb begin
        state_next = state_reg;
        if (wrEn) begin
            state_next.ctrlByte = wrData & FIELD_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '{ctrlByte: RESET_BYTE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.ctrlByte;
endmodule

// ---- uecc_ep_decode.sv ----
`timescale 1ns/100ps
// turns one control byte into the endpoint's per-transaction behaviour
module uecc_ep_decode (
    input wire logic [7:0] ctrlByte,
    input wire logic isSetup,
    input wire logic isIn,
    output logic accept,
    output logic stall,
    output logic handshake
);
    import uecc_pkg::*;
    logic rxOn;
    logic txOn;
    logic dirOk;

    // direction table; setup needs both directions and no setup disable
    always_comb begin
        rxOn = ctrlByte[EP_RX_DIR];
        txOn = ctrlByte[EP_TX_DIR];
        if (isSetup) begin
            dirOk = rxOn && txOn && !ctrlByte[EP_SETUP_DIS];
        end else if (isIn) begin
            dirOk = txOn;
        end else begin
            dirOk = rxOn;
        end
        // halt wins only on an endpoint with some direction enabled
        stall = ctrlByte[EP_HALT] && (rxOn || txOn);
        accept = dirOk && !stall;
        handshake = ctrlByte[EP_HANDSHAKE] || stall;
    end
endmodule

// ---- uecc_assertions.sv ----
`timescale 1ns/100ps
// port-level checks; host pulses are tied to the nak input that caused them
module uecc_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire uecc_pkg::uecc_hs_t tokenAnswer,
    input wire logic hostNakSeen,
    input wire logic hostRetry,
    input wire logic hostNakComplete,
    input wire logic [31:0] descriptorTableBaseAddress,
    input wire logic hostMode,
    input wire logic directLowSpeed,
    input wire logic sendPreamble,
    input wire logic nakRetryDisable,
    input wire logic [1:0] usbClockSelect,
    input wire logic usbClockSelectValid
);
    import uecc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_base_aligned: assert property (descriptorTableBaseAddress[23:0] == 24'h000000)
        else $error("table base not aligned");
    chk_nak_retried: assert property (hostNakSeen && hostMode && !nakRetryDisable |=> hostRetry && !hostNakComplete)
        else $error("nak not retried");
    chk_nak_reported: assert property (hostNakSeen && hostMode && nakRetryDisable |=> hostNakComplete && !hostRetry)
        else $error("nak not reported");
    chk_host_only_pulse: assert property (hostRetry || hostNakComplete |-> $past(hostNakSeen) && $past(hostMode))
        else $error("host pulse without cause");
    chk_preamble_choice: assert property (hostMode |-> sendPreamble == !directLowSpeed)
        else $error("preamble choice wrong");
    chk_peer_no_preamble: assert property (!hostMode |-> !sendPreamble)
        else $error("preamble outside host mode");
    chk_clock_valid: assert property (usbClockSelectValid == (usbClockSelect != CLKSEL_RSVD))
        else $error("clock select validity wrong");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_stall: cover property (tokenAnswer == UECC_HS_STALL);
    cov_nak_done: cover property (hostNakComplete);
endmodule
bind uecc_top uecc_checker u_chk (.clk, .rst, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .tokenAnswer, .hostNakSeen, .hostRetry,
    .hostNakComplete, .descriptorTableBaseAddress, .hostMode, .directLowSpeed, .sendPreamble,
    .nakRetryDisable, .usbClockSelect, .usbClockSelectValid);

// ---- uecc_engine_model.sv ----
`timescale 1ns/100ps
// serial engine stand-in: token levels and nak pulses
module uecc_engine_model (
    input wire logic clk,
    input wire uecc_pkg::uecc_hs_t tokenAnswer,
    input wire logic tokenAccept,
    input wire logic hostRetry,
    input wire logic hostNakComplete,
    output logic [3:0] tokenEndpoint,
    output logic tokenIsSetup,
    output logic tokenIsIn,
    output logic hostNakSeen
);
    import uecc_pkg::*;
    logic busy = 1'b0;
    initial begin
        tokenEndpoint = 4'h0;
        tokenIsSetup = 1'b0;
        tokenIsIn = 1'b0;
        hostNakSeen = 1'b0;
    end
    // idle endpoint and in lines wander each edge, setup held low, so a stale token never passes for a real one
    always @(posedge clk) begin
        if (!busy) begin
            tokenEndpoint <= tokenEndpoint + 4'h1;
            tokenIsIn <= !tokenIsIn;
            tokenIsSetup <= 1'b0;
        end
    end
    task automatic query(input logic [3:0] ep, input logic setup, input logic inTok,
                         output uecc_hs_t ans, output logic acc);
        busy = 1'b1;
        @(posedge clk);
        tokenEndpoint <= ep;
        tokenIsSetup <= setup;
        tokenIsIn <= inTok;
        @(posedge clk);
        #1;
        ans = tokenAnswer;
        acc = tokenAccept;
        busy = 1'b0;
    endtask
    task automatic nakPulse(output logic [1:0] res);
        @(posedge clk);
        hostNakSeen <= 1'b1;
        @(posedge clk);
        hostNakSeen <= 1'b0;
        #1;
        res = {hostRetry, hostNakComplete};
    endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
// register bus master plus engine model around the control block
module tb_top;
    import uecc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, descriptorTableBaseAddress;
    logic [3:0] s_axi_wstrb = 4'hf, tokenEndpoint;
    logic [1:0] s_axi_bresp, s_axi_rresp, usbClockSelect, nakRes;
    logic tokenIsSetup, tokenIsIn, tokenAccept, hostNakSeen, hostRetry, hostNakComplete, hostMode, acc;
    logic hostHandshakeEnable, directLowSpeed, sendPreamble, nakRetryDisable, transceiverSuspend;
    logic weakPulldownEnable, usbClockSelectValid;
    uecc_hs_t tokenAnswer, ans;
    int n_fail = 0, comparisons = 0;
    always #2.5 clk = ~clk;
    uecc_top u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tokenEndpoint, .tokenIsSetup,
        .tokenIsIn, .tokenAnswer, .tokenAccept, .hostNakSeen, .hostRetry, .hostNakComplete,
        .descriptorTableBaseAddress, .hostMode, .hostHandshakeEnable, .directLowSpeed, .sendPreamble,
        .nakRetryDisable, .transceiverSuspend, .weakPulldownEnable, .usbClockSelect, .usbClockSelectValid);
    uecc_engine_model u_eng (.clk, .tokenAnswer, .tokenAccept, .hostRetry, .hostNakComplete, .tokenEndpoint,
        .tokenIsSetup, .tokenIsIn, .hostNakSeen);
    task automatic tally_and_finish;
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ready raised only after valid shows, so the hold checks get exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int i;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                check(32'(s_axi_bresp), 32'(er));
                s_axi_bready <= 1'b0;
                break;
            end
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        if (i == 40) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int i;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                check(s_axi_rdata, exp);
                check(32'(s_axi_rresp), 32'(er));
                s_axi_rready <= 1'b0;
                break;
            end
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        if (i == 40) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    // every endpoint: zero after reset, reserved bits dropped, then cleared again
    task automatic s_registers;
        logic [7:0] a;
        for (int n = 0; n < UECC_NUM_EP; n++) begin
            a = UECC_OFS_EP_FIRST + 8'(4 * n);
            rd(a, 32'h00000000, RESP_OKAY);
            wr(a, 32'hffffffff, 4'hf, RESP_OKAY);
            rd(a, {24'h000000, n == 0 ? EP_MASK : EP_MASK_NONZERO}, RESP_OKAY);
            wr(a, 32'h00000000, 4'hf, RESP_OKAY);
        end
    endtask
    // base page, then refused and strobe-less accesses that must leave it untouched
    task automatic s_base_and_errors;
        wr(UECC_OFS_BASE_TOP, 32'h000000a5, 4'hf, RESP_OKAY);
        check(descriptorTableBaseAddress, 32'ha5000000);
        wr(8'h0c, 32'h000000ff, 4'hf, RESP_SLVERR);
        wr(8'h41, 32'h000000ff, 4'hf, RESP_SLVERR);
        rd(UECC_OFS_EP_FIRST, 32'h00000000, RESP_OKAY);
        wr(UECC_OFS_BASE_TOP, 32'h00000011, 4'h0, RESP_OKAY);
        rd(8'h10, 32'h00000000, RESP_SLVERR);
        rd(UECC_OFS_BASE_TOP, 32'h000000a5, RESP_OKAY);
    endtask
    task automatic s_transceiver;
        wr(UECC_OFS_XCVR_CTRL, 32'hffffffff, 4'hf, RESP_OKAY);
        rd(UECC_OFS_XCVR_CTRL, 32'h000000c3, RESP_OKAY);
        check(32'({transceiverSuspend, weakPulldownEnable}), 32'h3);
        for (int s = 0; s < 4; s++) begin
            wr(UECC_OFS_XCVR_CTRL, 32'(s), 4'hf, RESP_OKAY);
            check(32'({transceiverSuspend, weakPulldownEnable, usbClockSelect}), 32'(s));
            check(32'(usbClockSelectValid), 32'(s != 2));
        end
    endtask
    // rows: control byte, setup, in, expected answer, expected accept
    task automatic s_endpoint_modes;
        logic [12:0] rows [12] = '{13'h1b3, 13'h3b0, 13'h3a3, 13'h0ab, 13'h0a0, 13'h123, 13'h128, 13'h189,
                                   13'h008, 13'h1ec, 13'h1f4, 13'h048};
        for (int e = 0; e < 16; e += 15) begin
            foreach (rows[r]) begin
                wr(UECC_OFS_EP_FIRST + 8'(4 * e), 32'(rows[r][12:5]), 4'hf, RESP_OKAY);
                u_eng.query(4'(e), rows[r][4], rows[r][3], ans, acc);
                check(32'(ans), 32'(rows[r][2:1]));
                if (rows[r][2:1] != 2'h2) check(32'(acc), 32'(rows[r][0]));
            end
        end
    endtask
    // host role: endpoint zero drives handshake, retry and low-speed choices
    task automatic s_host_mode;
        wr(UECC_OFS_GEN_CTRL, 32'h00000001, 4'hf, RESP_OKAY);
        wr(UECC_OFS_EP_FIRST, 32'h0000004d, 4'hf, RESP_OKAY);
        check(32'({hostMode, hostHandshakeEnable, nakRetryDisable, sendPreamble}), 32'hf);
        u_eng.nakPulse(nakRes);
        check(32'(nakRes), 32'h1);
        wr(UECC_OFS_EP_FIRST, 32'h0000008c, 4'hf, RESP_OKAY);
        check(32'({hostHandshakeEnable, directLowSpeed, sendPreamble}), 32'h2);
        u_eng.nakPulse(nakRes);
        check(32'(nakRes), 32'h2);
        wr(UECC_OFS_GEN_CTRL, 32'h00000000, 4'hf, RESP_OKAY);
        u_eng.nakPulse(nakRes);
        check(32'({hostMode, sendPreamble, nakRes}), 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        s_registers();
        s_base_and_errors();
        s_transceiver();
        s_endpoint_modes();
        s_host_mode();
        tally_and_finish();
    end
endmodule
